//--- timer_pwm_pkg.sv
// Constants, register map and carrier types for the timer waveform unit
package timer_pwm_pkg;

    // ==========================================================
    // Register byte addresses (low 20 address bits are decoded)
    localparam int ADDR_W = 20;
    localparam logic [19:0] OFS_PIN_ROUTE = 20'h40840;
    localparam logic [19:0] OFS_WAVE_CTRL = 20'h40c04;
    localparam logic [19:0] OFS_COUNT_STAT = 20'h40c08;
    localparam logic [19:0] OFS_LIMIT = 20'h40c0c;
    localparam logic [19:0] OFS_COMPARE = 20'h40c10;
    localparam logic [19:0] OFS_TICK_DIV = 20'h40c14;

    // ==========================================================
    // Field positions
    localparam int TRIG_LSB = 0;
    localparam int METHOD_LSB = 2;
    localparam int CLEAR_BIT = 4;
    localparam int RUN_BIT = 5;
    localparam int OUT0_MODE_LSB = 16;
    localparam int OUT0_POL_BIT = 19;
    localparam int OUT1_MODE_LSB = 20;
    localparam int OUT1_POL_BIT = 23;
    localparam int FLAGS_LSB = 16;
    localparam int PIN_EN0_BIT = 0;
    localparam int PIN_EN1_BIT = 1;
    localparam int PIN_SEL_LSB = 2;
    localparam int FLAG_COUNT = 6;

    // ==========================================================
    // Values after reset
    localparam logic [31:0] RST_WORD = 32'h0;
    localparam logic [15:0] RST_HALF = 16'h0;
    localparam logic [7:0] RST_DIV = 8'h0;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        MODE_A, MODE_B, MODE_C, MODE_D, MODE_E, MODE_F, MODE_G, MODE_RSV
    } wave_mode_t;

    typedef enum logic [1:0] {
        CNT_UP16, CNT_UPDOWN16, CNT_DUAL8, CNT_CASCADE8
    } count_method_t;

    typedef struct packed {
        logic out1_pol;
        wave_mode_t out1_mode;
        logic out0_pol;
        wave_mode_t out0_mode;
        logic run;
        count_method_t method;
        logic [1:0] trig;
    } wave_ctrl_t;

    typedef struct packed {
        logic wr;
        logic [19:0] addr;
    } bus_phase_t;

endpackage

//--- timer_pwm_waveform_unit.sv
// Two-channel timer-driven waveform generator with AHB-Lite registers
`timescale 1ns/1ps
module timer_pwm_waveform_unit
    import timer_pwm_pkg::*;
#(
    parameter int PIN_COUNT = 8
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // External count trigger pin
    input wire logic ext_trigger,
    // Generator pins
    output logic [PIN_COUNT-1:0] gen0_pin_out,
    output logic [PIN_COUNT-1:0] gen0_pin_oe,
    output logic [PIN_COUNT-1:0] gen1_pin_out,
    output logic [PIN_COUNT-1:0] gen1_pin_oe
);

    // ==========================================================
    // Helpers
    function automatic logic [31:0] ctrl_word(input wave_ctrl_t c);
        logic [31:0] w;
        w = 32'h0;
        w[TRIG_LSB +: 2] = c.trig;
        w[METHOD_LSB +: 2] = c.method;
        w[RUN_BIT] = c.run;
        w[OUT0_MODE_LSB +: 3] = c.out0_mode;
        w[OUT0_POL_BIT] = c.out0_pol;
        w[OUT1_MODE_LSB +: 3] = c.out1_mode;
        w[OUT1_POL_BIT] = c.out1_pol;
        return w;
    endfunction

    // Lowest set bit of the period index picks the weight bit
    function automatic logic dither_extra(input logic [7:0] period,
                                          input logic [7:0] weight);
        logic [7:0] low_bit;
        low_bit = period & (~period + 8'h1);
        return |(weight & low_bit);
    endfunction

    // ==========================================================
    // State
    wave_ctrl_t ctrl_r, ctrl_nxt;
    logic [4:0] route_r, route_nxt;
    logic [15:0] limit_r, limit_nxt;
    logic [31:0] compare_r, compare_nxt;
    logic [7:0] div_r, div_nxt;
    bus_phase_t phase_r, phase_nxt;
    logic [31:0] hrdata_nxt;
    logic clear_req;
    logic [7:0] div_cnt_r, div_cnt_nxt;
    logic [15:0] count_r, count_nxt;
    logic down_r, down_nxt;
    logic trig_s1_r, trig_s2_r, trig_s3_r;
    logic [1:0] raw_r, raw_nxt;
    logic [1:0] drive_r, drive_nxt;
    logic [PIN_COUNT-1:0] p0_out_nxt, p0_oe_nxt, p1_out_nxt, p1_oe_nxt;
    logic tick, trig_ok, step;
    logic [FLAG_COUNT-1:0] flags;

    // ==========================================================
    // Bus slave
    // Zero wait state: read data is fetched in the address phase, so a
    // read issued right behind a write to the same word sees old data.
    always_comb begin
        logic valid;
        valid = hsel && htrans[1] && hready;
        phase_nxt.wr = valid && hwrite;
        phase_nxt.addr = haddr[ADDR_W-1:0];
        hrdata_nxt = hrdata;
        ctrl_nxt = ctrl_r;
        route_nxt = route_r;
        limit_nxt = limit_r;
        compare_nxt = compare_r;
        div_nxt = div_r;
        clear_req = 1'b0;
        if (valid && !hwrite) begin
            if (haddr[ADDR_W-1:0] == OFS_PIN_ROUTE) begin
                hrdata_nxt = {27'h0, route_r};
            end else if (haddr[ADDR_W-1:0] == OFS_WAVE_CTRL) begin
                hrdata_nxt = ctrl_word(ctrl_r);
            end else if (haddr[ADDR_W-1:0] == OFS_COUNT_STAT) begin
                hrdata_nxt = {10'h0, flags, count_r};
            end else if (haddr[ADDR_W-1:0] == OFS_LIMIT) begin
                hrdata_nxt = {16'h0, limit_r};
            end else if (haddr[ADDR_W-1:0] == OFS_COMPARE) begin
                hrdata_nxt = compare_r;
            end else if (haddr[ADDR_W-1:0] == OFS_TICK_DIV) begin
                hrdata_nxt = {24'h0, div_r};
            end else begin
                hrdata_nxt = 32'h0;
            end
        end
        if (phase_r.wr) begin
            if (phase_r.addr == OFS_PIN_ROUTE) begin
                route_nxt = hwdata[4:0];
            end else if (phase_r.addr == OFS_WAVE_CTRL) begin
                ctrl_nxt.trig = hwdata[TRIG_LSB +: 2];
                ctrl_nxt.method = count_method_t'(hwdata[METHOD_LSB +: 2]);
                ctrl_nxt.run = hwdata[RUN_BIT];
                ctrl_nxt.out0_mode = wave_mode_t'(hwdata[OUT0_MODE_LSB +: 3]);
                ctrl_nxt.out0_pol = hwdata[OUT0_POL_BIT];
                ctrl_nxt.out1_mode = wave_mode_t'(hwdata[OUT1_MODE_LSB +: 3]);
                ctrl_nxt.out1_pol = hwdata[OUT1_POL_BIT];
                clear_req = hwdata[CLEAR_BIT];
            end else if (phase_r.addr == OFS_LIMIT) begin
                limit_nxt = hwdata[15:0];
            end else if (phase_r.addr == OFS_COMPARE) begin
                compare_nxt = hwdata;
            end else if (phase_r.addr == OFS_TICK_DIV) begin
                div_nxt = hwdata[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_r <= '0;
            hrdata <= RST_WORD;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            ctrl_r <= '0;
            route_r <= '0;
            limit_r <= RST_HALF;
            compare_r <= RST_WORD;
            div_r <= RST_DIV;
        end else begin
            phase_r <= phase_nxt;
            hrdata <= hrdata_nxt;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            ctrl_r <= ctrl_nxt;
            route_r <= route_nxt;
            limit_r <= limit_nxt;
            compare_r <= compare_nxt;
            div_r <= div_nxt;
        end
    end

    // ==========================================================
    // Tick divider and trigger
    always_comb begin
        tick = (div_cnt_r == div_r);
        div_cnt_nxt = tick ? 8'h0 : div_cnt_r + 8'h1;
        case (ctrl_r.trig)
            2'b00: trig_ok = 1'b1;
            2'b01: trig_ok = trig_s2_r;
            2'b10: trig_ok = !trig_s2_r;
            default: trig_ok = trig_s2_r && !trig_s3_r;
        endcase
        step = ctrl_r.run && tick && trig_ok;
    end

    // ==========================================================
    // Shared counter
    always_comb begin
        count_nxt = count_r;
        down_nxt = down_r;
        if (clear_req) begin
            count_nxt = 16'h0;
            down_nxt = 1'b0;
        end else if (step) begin
            case (ctrl_r.method)
                CNT_UP16: begin
                    count_nxt = (count_r >= limit_r) ? 16'h0
                                                     : count_r + 16'h1;
                end
                CNT_UPDOWN16: begin
                    if (!down_r) begin
                        if (count_r >= limit_r) begin
                            down_nxt = 1'b1;
                            count_nxt = (count_r == 16'h0) ? 16'h0
                                                           : count_r - 16'h1;
                        end else begin
                            count_nxt = count_r + 16'h1;
                        end
                    end else if (count_r == 16'h0) begin
                        down_nxt = 1'b0;
                        count_nxt = 16'h1;
                    end else begin
                        count_nxt = count_r - 16'h1;
                    end
                end
                CNT_DUAL8: begin
                    count_nxt[15:8] = (count_r[15:8] >= limit_r[15:8]) ? 8'h0
                                      : count_r[15:8] + 8'h1;
                    count_nxt[7:0] = (count_r[7:0] >= limit_r[7:0]) ? 8'h0
                                     : count_r[7:0] + 8'h1;
                end
                default: begin
                    if (count_r[7:0] >= limit_r[7:0]) begin
                        count_nxt[7:0] = 8'h0;
                        count_nxt[15:8] = count_r[15:8] + 8'h1;
                    end else begin
                        count_nxt[7:0] = count_r[7:0] + 8'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt_r <= RST_DIV;
            count_r <= RST_HALF;
            down_r <= 1'b0;
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_s3_r <= 1'b0;
        end else begin
            div_cnt_r <= div_cnt_nxt;
            count_r <= count_nxt;
            down_r <= down_nxt;
            trig_s1_r <= ext_trigger;
            trig_s2_r <= trig_s1_r;
            trig_s3_r <= trig_s2_r;
        end
    end

    // ==========================================================
    // Waveform generators
    always_comb begin
        wave_mode_t mode;
        logic pol;
        logic [8:0] e_set;
        mode = MODE_A;
        pol = 1'b0;
        e_set = 9'h0;
        raw_nxt = raw_r;
        drive_nxt = drive_r;
        for (int g = 0; g < 2; g++) begin
            mode = (g == 0) ? ctrl_r.out0_mode : ctrl_r.out1_mode;
            pol = (g == 0) ? ctrl_r.out0_pol : ctrl_r.out1_pol;
            e_set = {1'b0, compare_r[7:0]}
                    + {8'h0, dither_extra(count_r[15:8],
                                          compare_r[23:16])};
            if (step) begin
                case (mode)
                    MODE_A: raw_nxt[g] = count_r >= compare_r[15:0];
                    MODE_B: raw_nxt[g] = count_r >= compare_r[31:16];
                    MODE_C: raw_nxt[g] = count_r[7:0] >= compare_r[7:0];
                    MODE_D: raw_nxt[g] = count_r[15:8] >= compare_r[23:16];
                    MODE_E: begin
                        if (ctrl_r.method != CNT_CASCADE8) begin
                            raw_nxt[g] = 1'b0;
                        end else if (count_r[7:0] == limit_r[7:0]) begin
                            raw_nxt[g] = 1'b0;
                        end else if ({1'b0, count_r[7:0]} == e_set) begin
                            raw_nxt[g] = 1'b1;
                        end
                    end
                    default: raw_nxt[g] = 1'b0;
                endcase
            end
            drive_nxt[g] = ctrl_r.run ? (raw_r[g] ^ pol) : pol;
        end
    end

    // ==========================================================
    // Pin routing, mode flags
    always_comb begin
        for (int k = 0; k < FLAG_COUNT; k++) begin
            flags[k] = ctrl_r.run && (ctrl_r.out0_mode == wave_mode_t'(k)
                       || ctrl_r.out1_mode == wave_mode_t'(k));
        end
        for (int i = 0; i < PIN_COUNT; i++) begin
            p0_oe_nxt[i] = route_r[PIN_EN0_BIT]
                           && (route_r[PIN_SEL_LSB +: 3] == 3'(i));
            p1_oe_nxt[i] = route_r[PIN_EN1_BIT]
                           && (route_r[PIN_SEL_LSB +: 3] == 3'(i));
            p0_out_nxt[i] = p0_oe_nxt[i] && drive_r[0];
            p1_out_nxt[i] = p1_oe_nxt[i] && drive_r[1];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            raw_r <= 2'h0;
            drive_r <= 2'h0;
            gen0_pin_out <= '0;
            gen0_pin_oe <= '0;
            gen1_pin_out <= '0;
            gen1_pin_oe <= '0;
        end else begin
            raw_r <= raw_nxt;
            drive_r <= drive_nxt;
            gen0_pin_out <= p0_out_nxt;
            gen0_pin_oe <= p0_oe_nxt;
            gen1_pin_out <= p1_out_nxt;
            gen1_pin_oe <= p1_oe_nxt;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_clear_zero;
        clear_req |=> count_r == 16'h0;
    endproperty
    a_clear_zero: assert property (p_clear_zero)
        else $error("count not cleared");

    property p_stop_hold;
        (!ctrl_r.run && !clear_req) |=> count_r == $past(count_r);
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("counter moved while stopped");

    property p_inactive_level;
        (!ctrl_r.run && !ctrl_r.out0_pol) [*3] |-> drive_r[0] == 1'b0;
    endproperty
    a_inactive_level: assert property (p_inactive_level)
        else $error("stopped output not inactive");

    property p_pin_disabled;
        !route_r[PIN_EN0_BIT] |=> gen0_pin_oe == '0 && gen0_pin_out == '0;
    endproperty
    a_pin_disabled: assert property (p_pin_disabled)
        else $error("disabled pin still driven");

    property p_mode_a;
        (step && ctrl_r.out0_mode == MODE_A)
            |=> raw_r[0] == ($past(count_r) >= $past(compare_r[15:0]));
    endproperty
    a_mode_a: assert property (p_mode_a)
        else $error("mode A compare wrong");

    property p_mode_d;
        (step && ctrl_r.out1_mode == MODE_D)
            |=> raw_r[1] == ($past(count_r[15:8]) >= $past(compare_r[23:16]));
    endproperty
    a_mode_d: assert property (p_mode_d)
        else $error("mode D compare wrong");

    property p_up16_wrap;
        (step && !clear_req && ctrl_r.method == CNT_UP16
            && count_r >= limit_r) |=> count_r == 16'h0;
    endproperty
    a_up16_wrap: assert property (p_up16_wrap)
        else $error("16-bit counter did not wrap");

    property p_cascade;
        (step && !clear_req && ctrl_r.method == CNT_CASCADE8
            && count_r[7:0] >= limit_r[7:0])
            |=> count_r[7:0] == 8'h0
                && count_r[15:8] == $past(count_r[15:8]) + 8'h1;
    endproperty
    a_cascade: assert property (p_cascade)
        else $error("cascade step wrong");

    property p_e_clear;
        (step && ctrl_r.out0_mode == MODE_E
            && count_r[7:0] == limit_r[7:0]) |=> raw_r[0] == 1'b0;
    endproperty
    a_e_clear: assert property (p_e_clear)
        else $error("mode E did not fall at limit");

endmodule

//--- timer_pwm_waveform_unit_bench.sv
// Self-checking bench for the timer waveform unit
`timescale 1ns/1ps
module timer_pwm_waveform_unit_bench;
    import timer_pwm_pkg::*;

    // ==========================================================
    // Clock, reset, bus and pin signals
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic ext_trigger = 1'b0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [7:0] g0_out;
    logic [7:0] g0_oe;
    logic [7:0] g1_out;
    logic [7:0] g1_oe;
    int n_errors = 0;
    int samples_checked = 0;
    int n_unknown = 0;

    always #4 hclk = ~hclk;

    timer_pwm_waveform_unit #(.PIN_COUNT(8)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ext_trigger(ext_trigger),
        .gen0_pin_out(g0_out), .gen0_pin_oe(g0_oe),
        .gen1_pin_out(g1_out), .gen1_pin_oe(g1_oe)
    );

    // ==========================================================
    // Ordinary cases: settings beside expected high counts in 200 cycles
    typedef struct {
        logic [31:0] cfg;
        logic [31:0] lim;
        logic [31:0] cmp;
        int h0;
        int h1;
        logic [5:0] flags;
    } row_t;
    row_t rows[6];

    // ==========================================================
    // Shared tasks
    task automatic end_of_test();
        $display("Checked %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_ready();
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            @(posedge hclk);
        end
    endtask

    // One single transfer; read data taken at the data phase edge
    task automatic bus(input logic wr, input logic [19:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {12'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        logic [31:0] junk;
        bus(1'b1, a, d, junk);
    endtask

    task automatic rd(input logic [19:0] a, output logic [31:0] v);
        bus(1'b0, a, 32'h0, v);
    endtask

    function automatic logic [31:0] mk(input wave_mode_t m0,
        input logic p0, input wave_mode_t m1, input logic p1,
        input logic [1:0] meth);
        mk = {8'h0, p1, m1, p0, m0, 12'h0, meth, 2'b00};
    endfunction

    // Configure first, clear, then run; settle past the output pipeline
    task automatic start(input logic [31:0] cfg, input logic [31:0] lim,
                         input logic [31:0] cmp);
        wr(OFS_WAVE_CTRL, cfg);
        wr(OFS_COMPARE, cmp);
        wr(OFS_LIMIT, lim);
        wr(OFS_WAVE_CTRL, cfg | 32'h10);
        wr(OFS_WAVE_CTRL, cfg | 32'h20);
        repeat (24) @(posedge hclk);
    endtask

    // Phase-free duty check: windows are whole waveform periods
    task automatic measure(input int n, output int h0, output int h1);
        h0 = 0;
        h1 = 0;
        repeat (n) begin
            @(posedge hclk);
            #1;
            if (g0_out[3] === 1'b1) h0++;
            if (g1_out[3] === 1'b1) h1++;
            if ($isunknown({g0_out[3], g1_out[3]})) n_unknown++;
        end
    endtask

    // ==========================================================
    // Watchdog: the whole run needs well under 5000 cycles
    initial begin
        repeat (20000) @(posedge hclk);
        n_errors++;
        $display("Error at %0t: watchdog expired", $time);
        end_of_test();
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] v;
        logic [31:0] v2;
        logic [31:0] cfg;
        logic [19:0] regs[7];
        int h0;
        int h1;
        int he[4];
        rows[0] = '{mk(MODE_A, 0, MODE_B, 0, CNT_UP16), 32'h9,
                    32'h0007_0004, 120, 60, 6'h03};
        rows[1] = '{mk(MODE_A, 1, MODE_B, 1, CNT_UP16), 32'h9,
                    32'h0007_0004, 80, 140, 6'h03};
        rows[2] = '{mk(MODE_C, 0, MODE_A, 0, CNT_UP16), 32'h9,
                    32'h0000_0104, 120, 0, 6'h05};
        rows[3] = '{mk(MODE_D, 0, MODE_C, 0, CNT_DUAL8), 32'h0309,
                    32'h0002_0004, 100, 120, 6'h0c};
        rows[4] = '{mk(MODE_A, 0, MODE_B, 0, CNT_UPDOWN16), 32'h5,
                    32'h0005_0003, 100, 20, 6'h03};
        rows[5] = '{mk(MODE_F, 0, MODE_D, 1, CNT_DUAL8), 32'h0309,
                    32'h0002_0004, 0, 100, 6'h28};
        regs = '{OFS_PIN_ROUTE, OFS_WAVE_CTRL, OFS_COUNT_STAT, OFS_LIMIT,
                 OFS_COMPARE, OFS_TICK_DIV, 20'h40c20};
        repeat (4) @(posedge hclk);
        chk({16'h0, g0_oe, g1_oe}, 32'h0);
        hresetn <= 1'b1;
        foreach (regs[i]) begin
            rd(regs[i], v);
            chk(v, 32'h0);
        end
        chk({31'h0, hresp}, 32'h0);
        // Read-only status and an unmapped place ignore writes
        wr(OFS_COUNT_STAT, 32'hffff_ffff);
        rd(OFS_COUNT_STAT, v);
        chk(v, 32'h0);
        wr(20'h40c20, 32'hffff_ffff);
        rd(20'h40c20, v);
        chk(v, 32'h0);
        wr(OFS_COMPARE, 32'ha5a5_5a5a);
        rd(OFS_COMPARE, v);
        chk(v, 32'ha5a5_5a5a);
        // Every pin selector value, both enables
        for (int s = 0; s < 8; s++) begin
            wr(OFS_PIN_ROUTE, {27'h0, 3'(s), 2'b11});
            repeat (3) @(posedge hclk);
            #1;
            chk({24'h0, g0_oe}, 32'h1 << s);
            chk({24'h0, g1_oe}, 32'h1 << s);
        end
        rd(OFS_PIN_ROUTE, v);
        chk(v, 32'h1f);
        wr(OFS_PIN_ROUTE, 32'h0f);
        foreach (rows[i]) begin
            start(rows[i].cfg, rows[i].lim, rows[i].cmp);
            measure(200, h0, h1);
            chk(h0, rows[i].h0);
            chk(h1, rows[i].h1);
            rd(OFS_COUNT_STAT, v);
            chk({26'h0, v[21:16]}, {26'h0, rows[i].flags});
        end
        // Stopped timer rests each output at its inactive level
        cfg = mk(MODE_A, 1, MODE_B, 0, CNT_UP16);
        wr(OFS_WAVE_CTRL, cfg);
        repeat (4) @(posedge hclk);
        measure(20, h0, h1);
        chk(h0, 20);
        chk(h1, 0);
        rd(OFS_COUNT_STAT, v);
        rd(OFS_COUNT_STAT, v2);
        chk(v2, v);
        wr(OFS_WAVE_CTRL, cfg | 32'h10);
        rd(OFS_COUNT_STAT, v);
        chk(v, 32'h0);
        rd(OFS_WAVE_CTRL, v);
        chk(v, cfg);
        // Count gated by the external trigger level
        wr(OFS_WAVE_CTRL, cfg | 32'h21);
        repeat (20) @(posedge hclk);
        rd(OFS_COUNT_STAT, v);
        chk({16'h0, v[15:0]}, 32'h0);
        ext_trigger <= 1'b1;
        repeat (20) @(posedge hclk);
        rd(OFS_COUNT_STAT, v);
        chk({31'h0, v[15:0] != 16'h0}, 32'h1);
        // Low-level trigger freezes while high; edge trigger steps once
        wr(OFS_WAVE_CTRL, cfg | 32'h22);
        rd(OFS_COUNT_STAT, v);
        rd(OFS_COUNT_STAT, v2);
        chk(v2, v);
        ext_trigger <= 1'b0;
        wr(OFS_WAVE_CTRL, cfg | 32'h23);
        rd(OFS_COUNT_STAT, v);
        ext_trigger <= 1'b1;
        repeat (6) @(posedge hclk);
        rd(OFS_COUNT_STAT, v2);
        chk({16'h0, v2[15:0]}, {16'h0, v[15:0] + 16'h1});
        // Disabled pins stop their output
        wr(OFS_PIN_ROUTE, 32'h0d);
        repeat (3) @(posedge hclk);
        #1;
        chk({16'h0, g0_oe, g1_oe}, 32'h0800);
        wr(OFS_PIN_ROUTE, 32'h0f);
        // Dithered mode: an N+1 period drops one high tick when the weight bit picked by its index is set
        for (int w = 0; w < 4; w++) begin
            start(mk(MODE_E, 0, MODE_E, 1, CNT_CASCADE8), 32'hff09,
                  {8'h0, 8'(w), 16'h0004});
            measure(400, he[w], h1);
            chk(h1, 400 - he[w]);
        end
        chk({31'h0, he[0] != 0}, 32'h1);
        chk(he[0] - he[1], 20);
        chk(he[0] - he[2], 10);
        chk(he[0] - he[3], 30);
        rd(OFS_COUNT_STAT, v);
        chk({26'h0, v[21:16]}, 32'h10);
        chk(n_unknown, 0);
        // Reset in mid-run returns pins and registers to rest
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        #1;
        chk({g0_out, g0_oe, g1_out, g1_oe}, 32'h0);
        hresetn <= 1'b1;
        rd(OFS_WAVE_CTRL, v);
        chk(v, 32'h0);
        rd(OFS_COUNT_STAT, v);
        chk(v, 32'h0);
        end_of_test();
    end
endmodule
